// ---- acd_top.sv ----
// register file and divider gating for the audio clock divider block
`timescale 1ns/1ps
module acd_top
  import acd_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic AUTO_DETECT_ON,
  input wire logic [8:0] AUTO_PRI_RATIO,
  input wire logic [8:0] AUTO_SEC_RATIO,
  input wire logic [5:0] AUTO_NM_RATIO,
  input wire logic PRI_SRC_TICK,
  input wire logic SEC_SRC_TICK,
  input wire logic NM_SRC_TICK,
  input wire logic PLL_CLK_IN,
  input wire logic CTRL_PORT_CLK_IN,
  input wire logic OSC_CLK_IN,
  input wire logic DSP_CLK_IN,
  output logic PRI_BITCLK,
  output logic PRI_BITCLK_TICK,
  output logic SEC_BITCLK,
  output logic SEC_BITCLK_TICK,
  output logic ANALOG_NM_CLK,
  output logic ANALOG_NM_TICK,
  output logic FIRST_STAGE_DIVIDER_ON,
  output logic SECOND_STAGE_DIVIDER_ON,
  output logic DENSITY_CLOCK_DIVIDER_ON,
  output logic MODULATOR_CLOCK_DIVIDER_ON,
  output logic PRIMARY_FRAMESYNC_DIVIDER_ON,
  output logic SECONDARY_FRAMESYNC_DIVIDER_ON,
  output logic GP_CLOCK_OUT
);
  // stored register bytes
  logic [7:0] top_bits_q, top_bits_d;
  logic [7:0] pri_low_q, pri_low_d;
  logic [7:0] sec_low_q, sec_low_d;
  logic [7:0] nm_q, nm_d;
  logic [7:0] pll_en_q, pll_en_d;
  logic [7:0] if_en_q, if_en_d;
  logic [7:0] cko_sel_q, cko_sel_d;
  logic [7:0] rdata_q, rdata_d;

  // effective divider codes
  logic [ACD_BCLK_CODE_W-1:0] pri_manual_code;
  logic [ACD_BCLK_CODE_W-1:0] sec_manual_code;
  logic [ACD_BCLK_CODE_W-1:0] pri_code;
  logic [ACD_BCLK_CODE_W-1:0] sec_code;
  logic [ACD_NM_CODE_W-1:0] nm_code;
  logic pri_bclk_on;
  logic sec_bclk_on;
  logic pri_bclk;
  logic sec_bclk;

  // write path; bits that cannot be written stay at zero
  always_comb begin
    top_bits_d = top_bits_q;
    pri_low_d = pri_low_q;
    sec_low_d = sec_low_q;
    nm_d = nm_q;
    pll_en_d = pll_en_q;
    if_en_d = if_en_q;
    cko_sel_d = cko_sel_q;
    if (REG_WR) begin
      unique case (REG_ADDR)
        ACD_TOP_BITS_OFS: top_bits_d = REG_WDATA & ACD_TOP_BITS_MASK;
        ACD_PRI_LOW_OFS: pri_low_d = REG_WDATA;
        ACD_SEC_LOW_OFS: sec_low_d = REG_WDATA;
        ACD_NM_OFS: nm_d = REG_WDATA & ACD_NM_MASK;
        ACD_PLL_EN_OFS: pll_en_d = REG_WDATA & ACD_PLL_EN_MASK;
        // reserved bits stored as written
        ACD_IF_EN_OFS: if_en_d = REG_WDATA;
        ACD_CKO_SEL_OFS: cko_sel_d = REG_WDATA & ACD_CKO_SEL_MASK;
        default: ;
      endcase
    end
  end

  // read path; unmapped offsets read zero
  always_comb begin
    rdata_d = rdata_q;
    if (REG_RD) begin
      unique case (REG_ADDR)
        ACD_TOP_BITS_OFS: rdata_d = top_bits_q;
        ACD_PRI_LOW_OFS: rdata_d = pri_low_q;
        ACD_SEC_LOW_OFS: rdata_d = sec_low_q;
        ACD_NM_OFS: rdata_d = nm_q;
        ACD_PLL_EN_OFS: rdata_d = pll_en_q;
        ACD_IF_EN_OFS: rdata_d = if_en_q;
        ACD_CKO_SEL_OFS: rdata_d = cko_sel_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // register bank
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      top_bits_q <= ACD_TOP_BITS_RST;
      pri_low_q <= ACD_PRI_LOW_RST;
      sec_low_q <= ACD_SEC_LOW_RST;
      nm_q <= ACD_NM_RST;
      pll_en_q <= ACD_PLL_EN_RST;
      if_en_q <= ACD_IF_EN_RST;
      cko_sel_q <= ACD_CKO_SEL_RST;
      rdata_q <= 8'h00;
    end else begin
      top_bits_q <= top_bits_d;
      pri_low_q <= pri_low_d;
      sec_low_q <= sec_low_d;
      nm_q <= nm_d;
      pll_en_q <= pll_en_d;
      if_en_q <= if_en_d;
      cko_sel_q <= cko_sel_d;
      rdata_q <= rdata_d;
    end
  end

  assign pri_manual_code = {top_bits_q[ACD_PRI_TOP_BIT], pri_low_q};
  assign sec_manual_code = {top_bits_q[ACD_SEC_TOP_BIT], sec_low_q};

  assign pri_code = AUTO_DETECT_ON ? AUTO_PRI_RATIO : pri_manual_code;
  assign sec_code = AUTO_DETECT_ON ? AUTO_SEC_RATIO : sec_manual_code;
  assign nm_code = AUTO_DETECT_ON ? AUTO_NM_RATIO : nm_q[ACD_NM_CODE_W-1:0];

  assign pri_bclk_on = if_en_q[ACD_PRI_BCLK_BIT];
  assign sec_bclk_on = if_en_q[ACD_SEC_BCLK_BIT];

  acd_divider #(.W(ACD_BCLK_CODE_W)) u_pri_div (
    .clk(CLOCK),
    .rst_n(RSTN),
    .enable(pri_bclk_on),
    .src_tick(PRI_SRC_TICK),
    .code(pri_code),
    .div_clk(pri_bclk),
    .div_tick(PRI_BITCLK_TICK)
  );

  acd_divider #(.W(ACD_BCLK_CODE_W)) u_sec_div (
    .clk(CLOCK),
    .rst_n(RSTN),
    .enable(sec_bclk_on),
    .src_tick(SEC_SRC_TICK),
    .code(sec_code),
    .div_clk(sec_bclk),
    .div_tick(SEC_BITCLK_TICK)
  );

  // analog divider, clocked whenever the second stage runs
  acd_divider #(.W(ACD_NM_CODE_W)) u_nm_div (
    .clk(CLOCK),
    .rst_n(RSTN),
    .enable(pll_en_q[ACD_SECOND_STAGE_BIT]),
    .src_tick(NM_SRC_TICK),
    .code(nm_code),
    .div_clk(ANALOG_NM_CLK),
    .div_tick(ANALOG_NM_TICK)
  );

  assign PRI_BITCLK = pri_bclk;
  assign SEC_BITCLK = sec_bclk;

  assign FIRST_STAGE_DIVIDER_ON = pll_en_q[ACD_FIRST_STAGE_BIT];
  assign SECOND_STAGE_DIVIDER_ON = pll_en_q[ACD_SECOND_STAGE_BIT];
  assign DENSITY_CLOCK_DIVIDER_ON = pll_en_q[ACD_DENSITY_BIT];
  assign MODULATOR_CLOCK_DIVIDER_ON = if_en_q[ACD_MODULATOR_BIT];
  assign PRIMARY_FRAMESYNC_DIVIDER_ON = if_en_q[ACD_PRI_FSYNC_BIT];
  assign SECONDARY_FRAMESYNC_DIVIDER_ON = if_en_q[ACD_SEC_FSYNC_BIT];

  acd_clkout_sel u_cko (
    .clk(CLOCK),
    .rst_n(RSTN),
    .sel(cko_sel_q[2:0]),
    .sources({DSP_CLK_IN, OSC_CLK_IN, CTRL_PORT_CLK_IN, sec_bclk, pri_bclk, PLL_CLK_IN}),
    .clk_out(GP_CLOCK_OUT)
  );

  assign REG_RDATA = rdata_q;
endmodule : acd_top

// ---- acd_pkg.sv ----
// shared constants for the audio clock divider configuration block
package acd_pkg;
  // register offsets on the control port
  localparam logic [7:0] ACD_TOP_BITS_OFS = 8'h3B;
  localparam logic [7:0] ACD_PRI_LOW_OFS = 8'h3C;
  localparam logic [7:0] ACD_SEC_LOW_OFS = 8'h3D;
  localparam logic [7:0] ACD_NM_OFS = 8'h3E;
  localparam logic [7:0] ACD_PLL_EN_OFS = 8'h44;
  localparam logic [7:0] ACD_IF_EN_OFS = 8'h45;
  localparam logic [7:0] ACD_CKO_SEL_OFS = 8'h46;
  // reset values
  localparam logic [7:0] ACD_TOP_BITS_RST = 8'h00;
  localparam logic [7:0] ACD_PRI_LOW_RST = 8'h01;
  localparam logic [7:0] ACD_SEC_LOW_RST = 8'h01;
  localparam logic [7:0] ACD_NM_RST = 8'h01;
  localparam logic [7:0] ACD_PLL_EN_RST = 8'h00;
  localparam logic [7:0] ACD_IF_EN_RST = 8'h00;
  localparam logic [7:0] ACD_CKO_SEL_RST = 8'h00;
  // writable bit masks; other bits read as zero
  localparam logic [7:0] ACD_TOP_BITS_MASK = 8'hFE;
  localparam logic [7:0] ACD_NM_MASK = 8'h3F;
  localparam logic [7:0] ACD_PLL_EN_MASK = 8'h07;
  localparam logic [7:0] ACD_CKO_SEL_MASK = 8'h07;
  // field positions
  localparam int ACD_PRI_TOP_BIT = 2;
  localparam int ACD_SEC_TOP_BIT = 1;
  localparam int ACD_FIRST_STAGE_BIT = 2;
  localparam int ACD_SECOND_STAGE_BIT = 1;
  localparam int ACD_DENSITY_BIT = 0;
  localparam int ACD_MODULATOR_BIT = 4;
  localparam int ACD_PRI_BCLK_BIT = 3;
  localparam int ACD_SEC_BCLK_BIT = 2;
  localparam int ACD_PRI_FSYNC_BIT = 1;
  localparam int ACD_SEC_FSYNC_BIT = 0;
  // divider code widths; code zero means two to this power
  localparam int ACD_BCLK_CODE_W = 9;
  localparam int ACD_NM_CODE_W = 6;
  // clock output source codes
  typedef enum logic [2:0] {
    ACD_SRC_PLL, ACD_SRC_PRI_BCLK, ACD_SRC_SEC_BCLK,
    ACD_SRC_CTRL_CLK, ACD_SRC_OSC, ACD_SRC_DSP, ACD_SRC_RSV6, ACD_SRC_RSV7
  } acd_src_e;
endpackage : acd_pkg

// ---- acd_divider.sv ----
// gated programmable divider counting source ticks
`timescale 1ns/1ps
module acd_divider #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic src_tick,
  input wire logic [W-1:0] code,
  output logic div_clk,
  output logic div_tick
);
  logic [W:0] cnt_q, cnt_d;
  logic out_q, out_d;
  logic tick_q, tick_d;
  logic [W:0] ratio;
  logic [W:0] last;

  // code zero stands for the full power of two
  assign ratio = (code == '0) ? {1'b1, {W{1'b0}}} : {1'b0, code};
  assign last = ratio - {{W{1'b0}}, 1'b1};

  // count ticks; high for the first half of each period
  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    tick_d = 1'b0;
    if (!enable) begin
      cnt_d = '0;
      out_d = 1'b0;
    end else if (src_tick) begin
      cnt_d = (cnt_q >= last) ? '0 : cnt_q + {{W{1'b0}}, 1'b1};
      tick_d = (cnt_q >= last);
      out_d = (ratio == {{W{1'b0}}, 1'b1}) ? 1'b1 : (cnt_d < (ratio >> 1));
    end else if (ratio == {{W{1'b0}}, 1'b1}) begin
      out_d = 1'b0; // divide by one echoes the tick
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      out_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
      tick_q <= tick_d;
    end
  end

  assign div_clk = out_q;
  assign div_tick = tick_q;
endmodule : acd_divider

// ---- acd_clkout_sel.sv ----
// source selection for the general purpose clock output
`timescale 1ns/1ps
module acd_clkout_sel
  import acd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] sel,
  input wire logic [5:0] sources,
  output logic clk_out
);
  logic out_q, out_d;

  // pick one source; reserved codes give a quiet low output
  always_comb begin
    unique case (acd_src_e'(sel))
      ACD_SRC_PLL: out_d = sources[0];
      ACD_SRC_PRI_BCLK: out_d = sources[1];
      ACD_SRC_SEC_BCLK: out_d = sources[2];
      ACD_SRC_CTRL_CLK: out_d = sources[3];
      ACD_SRC_OSC: out_d = sources[4];
      ACD_SRC_DSP: out_d = sources[5];
      default: out_d = 1'b0;
    endcase
  end

  // output register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  assign clk_out = out_q;
endmodule : acd_clkout_sel

// ---- acd_chk.sv ----
// port assertions for the audio clock divider block
`timescale 1ns/1ps
module acd_chk (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic CTRL_PORT_CLK_IN,
  input wire logic PRI_BITCLK,
  input wire logic SEC_BITCLK,
  input wire logic SECOND_STAGE_DIVIDER_ON,
  input wire logic MODULATOR_CLOCK_DIVIDER_ON,
  input wire logic GP_CLOCK_OUT
);
  logic [2:0] sel_q;
  logic [2:0] sel_d;
  logic [7:0] ifen_q;
  logic [7:0] ifen_d;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // shadow copies of the source select and interface enables
  always_comb begin
    sel_d = sel_q;
    ifen_d = ifen_q;
    if (REG_WR && REG_ADDR == 8'h46) sel_d = REG_WDATA[2:0];
    if (REG_WR && REG_ADDR == 8'h45) ifen_d = REG_WDATA;
  end
  // shadow registers, cleared by reset
  always_ff @(posedge CLOCK) begin
    sel_q <= RSTN ? sel_d : 3'h0;
    ifen_q <= RSTN ? ifen_d : 8'h00;
  end
  mod_enable_a: assert property (
    REG_WR && REG_ADDR == 8'h45 |=> MODULATOR_CLOCK_DIVIDER_ON == $past(REG_WDATA[4]))
    else $error("modulator enable wrong");
  stage_enable_a: assert property (
    REG_WR && REG_ADDR == 8'h44 |=> SECOND_STAGE_DIVIDER_ON == $past(REG_WDATA[1]))
    else $error("second stage enable wrong");
  pll_rsv_a: assert property (
    REG_RD && REG_ADDR == 8'h44 |=> REG_RDATA[7:3] == 5'h00)
    else $error("pll enable reserved bits not zero");
  nm_rsv_a: assert property (
    REG_RD && REG_ADDR == 8'h3E |=> REG_RDATA[7:6] == 2'h0)
    else $error("analog ratio reserved bits not zero");
  ifen_read_a: assert property (
    REG_RD && REG_ADDR == 8'h45 |=> REG_RDATA == $past(ifen_q))
    else $error("interface enable readback wrong");
  pri_off_a: assert property (
    REG_WR && REG_ADDR == 8'h45 && !REG_WDATA[3] |=> ##1 !PRI_BITCLK)
    else $error("disabled primary bit clock not low");
  sec_off_a: assert property (
    REG_WR && REG_ADDR == 8'h45 && !REG_WDATA[2] |=> ##1 !SEC_BITCLK)
    else $error("disabled secondary bit clock not low");
  cko_ctrl_a: assert property (
    sel_q == 3'h3 && $past(sel_q) == 3'h3 |-> GP_CLOCK_OUT == $past(CTRL_PORT_CLK_IN))
    else $error("clock output not control clock");
  cko_rsv_a: assert property (
    sel_q[2:1] == 2'h3 && $past(sel_q[2:1]) == 2'h3 |-> !GP_CLOCK_OUT)
    else $error("reserved source not low");
endmodule : acd_chk
bind acd_top acd_chk acd_chk_inst (.CLOCK(CLOCK), .RSTN(RSTN), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .CTRL_PORT_CLK_IN(CTRL_PORT_CLK_IN), .PRI_BITCLK(PRI_BITCLK), .SEC_BITCLK(SEC_BITCLK),
  .SECOND_STAGE_DIVIDER_ON(SECOND_STAGE_DIVIDER_ON), .GP_CLOCK_OUT(GP_CLOCK_OUT),
  .MODULATOR_CLOCK_DIVIDER_ON(MODULATOR_CLOCK_DIVIDER_ON));

// ---- acd_top_test.sv ----
// self-checking bench for the audio clock divider block
`timescale 1ns/1ps
module acd_top_test;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tick = 1'b1;
  logic auto_on = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [3:0] sc = 4'h0;
  wire logic [5:0] en;
  wire logic [2:0] bck;
  wire logic [2:0] tck;
  logic gp;
  logic e;
  int n;
  int h;
  int err_count = 0;
  int total_checks = 0;
  logic [7:0] ra [8] = '{8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h44, 8'h45, 8'h46, 8'h50};
  logic [7:0] rv [8] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] la [7] = '{8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h3D, 8'h3E, 8'h3E};
  logic [7:0] lv [7] = '{8'h04, 8'h00, 8'h01, 8'hFF, 8'h03, 8'h00, 8'h3F};
  logic [7:0] tt [7] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h00, 8'h00};
  int ps [7] = '{0, 0, 0, 0, 1, 2, 2};
  int pe [7] = '{4, 512, 1, 511, 259, 64, 63};
  acd_top acd_top_inst (.CLOCK(clock), .RSTN(rstn), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .AUTO_DETECT_ON(auto_on),
    .AUTO_PRI_RATIO(9'h006), .AUTO_SEC_RATIO(9'h000), .AUTO_NM_RATIO(6'h05),
    .PRI_SRC_TICK(tick), .SEC_SRC_TICK(tick), .NM_SRC_TICK(tick), .PLL_CLK_IN(sc[0]),
    .CTRL_PORT_CLK_IN(sc[1]), .OSC_CLK_IN(sc[2]), .DSP_CLK_IN(sc[3]),
    .PRI_BITCLK(bck[0]), .PRI_BITCLK_TICK(tck[0]), .SEC_BITCLK(bck[1]),
    .SEC_BITCLK_TICK(tck[1]), .ANALOG_NM_CLK(bck[2]), .ANALOG_NM_TICK(tck[2]),
    .FIRST_STAGE_DIVIDER_ON(en[5]), .SECOND_STAGE_DIVIDER_ON(en[4]),
    .DENSITY_CLOCK_DIVIDER_ON(en[3]), .MODULATOR_CLOCK_DIVIDER_ON(en[2]),
    .PRIMARY_FRAMESYNC_DIVIDER_ON(en[1]), .SECONDARY_FRAMESYNC_DIVIDER_ON(en[0]),
    .GP_CLOCK_OUT(gp));
  // clock and free-running source levels
  initial forever #25 clock = ~clock;
  always @(posedge clock) sc <= sc + 4'h1;
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    chk("rdata", {8'h00, rdata}, {8'h00, exp});
  endtask : rd_reg
  // skips two wraps so a code change settles, then times one period
  task automatic per(input int s, input int exp);
    repeat (2) begin
      n = 0;
      while (tck[s] !== 1'b1 && n < 1200) begin
        @(posedge clock);
        n++;
      end
      @(posedge clock);
    end
    // one full period of samples, counting the high ones as well
    n = 1;
    h = (bck[s] === 1'b1) ? 1 : 0;
    while (tck[s] !== 1'b1 && n < 1200) begin
      @(posedge clock);
      n++;
      if (bck[s] === 1'b1) h++;
    end
    chk("period", 16'(n), 16'(exp));
    chk("high_time", 16'(h), 16'((exp == 1) ? 1 : exp / 2));
  endtask : per
  function automatic logic src(int s);
    case (s)
      0: return sc[0];
      1: return bck[0];
      2: return bck[1];
      3: return sc[1];
      4: return sc[2];
      5: return sc[3];
      default: return 1'b0;
    endcase
  endfunction : src
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  // watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    foreach (ra[i]) rd_reg(ra[i], rv[i]);
    wr_reg(8'h44, 8'h07);
    rd_reg(8'h44, 8'h07);
    wr_reg(8'h45, 8'h13);
    rd_reg(8'h45, 8'h13);
    chk("enables", {10'h000, en}, 16'h003F);
    wr_reg(8'h44, 8'h05);
    wr_reg(8'h45, 8'h02);
    rd_reg(8'h3E, 8'h01);
    chk("enables", {10'h000, en}, 16'h002A);
    wr_reg(8'h44, 8'h02);
    wr_reg(8'h45, 8'h0C);
    for (int i = 0; i < 7; i++) begin
      wr_reg(8'h3B, tt[i]);
      wr_reg(la[i], lv[i]);
      per(ps[i], pe[i]);
    end
    rd_reg(8'h3E, 8'h3F);
    @(posedge clock);
    auto_on <= 1'b1;
    per(0, 6);
    per(1, 512);
    per(2, 5);
    auto_on <= 1'b0;
    wr_reg(8'h45, 8'h04);
    // let the divider register its disabled state first
    @(posedge clock);
    n = 0;
    repeat (600) begin
      @(posedge clock);
      if (tck[0] !== 1'b0 || bck[0] !== 1'b0) n++;
    end
    chk("pri_stopped", 16'(n), 16'h0000);
    wr_reg(8'h45, 8'h0C);
    per(0, 255);
    for (int s = 0; s < 8; s++) begin
      wr_reg(8'h46, {5'h00, 3'(s)});
      rd_reg(8'h46, {5'h00, 3'(s)});
      repeat (6) begin
        e = src(s);
        @(posedge clock);
        chk("gp_out", {15'h0000, gp}, {15'h0000, e});
      end
    end
    end_sim();
  end
endmodule : acd_top_test
